/* include/cies_pkg.sv */
/*
 * cies_pkg: shared constants, opcodes and decode helpers for the instruction
 * execution core subset.
 * Assumes a 14-bit instruction word, 8-bit data and a 7-bit file address.
 */
package cies_pkg;

	localparam int INSTR_W     = 14;
	localparam int PC_W        = 13;
	localparam int DATA_W      = 8;
	localparam int FADDR_W     = 7;
	localparam int APB_AW      = 12;
	localparam int STACK_DEPTH = 8;
	localparam int WDT_PRE_W   = 7;

	// instruction fields
	localparam int OP_MSB   = 13;
	localparam int OP_LSB   = 10;
	localparam int DEST_BIT = 7;

	typedef enum logic [3:0] {
		OP_IDLE      = 4'h0,
		OP_LOAD_LIT  = 4'h1,
		OP_IRQ_RET   = 4'h2,
		OP_STORE_ACC = 4'h3,
		OP_RET_LIT   = 4'h4,
		OP_ROT_LEFT  = 4'h5,
		OP_ROT_RIGHT = 4'h6,
		OP_SLEEP     = 4'h7,
		OP_RETURN    = 4'h8,
		OP_LIT_SUB   = 4'h9,
		OP_REG_SUB   = 4'ha,
		OP_NIB_SWAP  = 4'hb,
		OP_XOR_REG   = 4'hc,
		OP_XOR_LIT   = 4'hd,
		OP_RSVD_E    = 4'he,
		OP_RSVD_F    = 4'hf
	} cies_op_e;

	// register byte offsets
	localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h000;
	localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
	localparam logic [APB_AW-1:0] OFS_ACC    = 12'h008;
	localparam logic [APB_AW-1:0] OFS_PC     = 12'h00c;
	localparam logic [APB_AW-1:0] OFS_STACK  = 12'h010;
	localparam logic [APB_AW-1:0] OFS_WDT    = 12'h014;

	// control fields
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_WAKE_BIT   = 1;
	localparam int CTRL_GIE_BIT    = 2;
	localparam int CTRL_WDT_EN_BIT = 3;

	// reset values
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
	localparam logic [DATA_W-1:0] WDT_CLR  = 8'h00;
	localparam logic              PD_RST   = 1'b1;
	localparam logic              TO_RST   = 1'b1;

	function automatic cies_op_e op_of(input logic [INSTR_W-1:0] ir);
		return cies_op_e'(ir[OP_MSB:OP_LSB]);
	endfunction : op_of

	// ops that read a file register operand
	function automatic logic reads_freg(input cies_op_e op);
		return (op == OP_ROT_LEFT) || (op == OP_ROT_RIGHT) || (op == OP_REG_SUB) ||
			(op == OP_NIB_SWAP) || (op == OP_XOR_REG);
	endfunction : reads_freg

endpackage : cies_pkg

/* rtl/cies_alu.sv */
/*
 * cies_alu: combinational result and flag logic for the executed subset.
 * Assumes the caller applies the update strobes and routes the result.
 */
`timescale 1ns/1ps
module cies_alu (
	input  wire cies_pkg::cies_op_e      op_i,
	input  wire logic [7:0]              acc_i,
	input  wire logic [7:0]              freg_i,
	input  wire logic [7:0]              lit_i,
	input  wire logic                    carry_i,
	output logic      [7:0]              res_o,
	output logic                         c_o,
	output logic                         dc_o,
	output logic                         z_o,
	output logic                         upd_c_o,
	output logic                         upd_dc_o,
	output logic                         upd_z_o
);

	logic [7:0] sub_a;

	always_comb
	begin
		res_o    = acc_i;
		c_o      = carry_i;
		dc_o     = 1'b0;
		upd_c_o  = 1'b0;
		upd_dc_o = 1'b0;
		upd_z_o  = 1'b0;
		sub_a    = (op_i == cies_pkg::OP_LIT_SUB) ? lit_i : freg_i;
		unique case (op_i)
			cies_pkg::OP_LOAD_LIT, cies_pkg::OP_RET_LIT: res_o = lit_i;
			cies_pkg::OP_ROT_LEFT:
			begin
				res_o   = {freg_i[6:0], carry_i};
				c_o     = freg_i[7];
				upd_c_o = 1'b1;
			end
			cies_pkg::OP_ROT_RIGHT:
			begin
				res_o   = {carry_i, freg_i[7:1]};
				c_o     = freg_i[0];
				upd_c_o = 1'b1;
			end
			cies_pkg::OP_LIT_SUB, cies_pkg::OP_REG_SUB:
			begin
				// carry and nibble flag read as "no borrow"
				res_o    = sub_a - acc_i;
				c_o      = (sub_a >= acc_i);
				dc_o     = (sub_a[3:0] >= acc_i[3:0]);
				upd_c_o  = 1'b1;
				upd_dc_o = 1'b1;
				upd_z_o  = 1'b1;
			end
			cies_pkg::OP_NIB_SWAP: res_o = {freg_i[3:0], freg_i[7:4]};
			cies_pkg::OP_XOR_REG:
			begin
				res_o   = acc_i ^ freg_i;
				upd_z_o = 1'b1;
			end
			cies_pkg::OP_XOR_LIT:
			begin
				res_o   = acc_i ^ lit_i;
				upd_z_o = 1'b1;
			end
			default: res_o = acc_i;
		endcase
		z_o = (res_o == 8'h00);
	end

endmodule : cies_alu

/* rtl/cies_wdt.sv */
/*
 * cies_wdt: watchdog counter with prescaler.
 * Assumes it runs on the core clock and keeps counting while the core sleeps.
 */
`timescale 1ns/1ps
module cies_wdt #(
	parameter int PRE_W = cies_pkg::WDT_PRE_W
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       en_i,
	input  wire logic       clr_i,
	output logic      [7:0] count_o,
	output logic            ovf_o
);

	logic [PRE_W-1:0] pre_q;
	logic             tick;

	assign tick = en_i && (pre_q == {PRE_W{1'b1}});

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || clr_i)
		begin
			pre_q   <= '0;
			count_o <= cies_pkg::WDT_CLR;
		end
		else if (en_i)
		begin
			pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
			if (tick)
				count_o <= count_o + 8'h01;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || clr_i)
			ovf_o <= 1'b0;
		else
			ovf_o <= tick && (count_o == 8'hff);
	end

endmodule : cies_wdt

/* rtl/cies_core.sv */
/*
 * cies_core: executes the instruction subset, with APB register access,
 * a program memory fetch port, a file register port and a return stack.
 * Assumes both memories answer one cycle after their read strobe, on CLK_I.
 */
// Operation
// RULE1: load literal copies 8-bit immediate into accumulator, flags unchanged.
// RULE2: interrupt return loads PC from stack top and sets interrupt enable.
// RULE3: store accumulator writes it to addressed file register, flags unchanged.
// RULE4: literal return loads immediate into accumulator, pops PC, two cycles.
// RULE5: rotate left through carry; only carry changes.
// RULE6: rotate right through carry; only carry changes.
// RULE7: destination bit 0 selects accumulator, 1 selects the file register.
// RULE8: sleep clears watchdog and prescaler, sets expiry flag, clears sleep flag.
// RULE9: after sleep the core halts with the oscillator stopped.
// RULE10: subroutine return pops stack into PC in two cycles, flags unchanged.
// RULE11: literal minus accumulator into accumulator, updating carry, nibble and zero.
// RULE12: register minus accumulator, routed by destination, updating three flags.
// RULE13: nibble swap of addressed register, routed by destination, no flags.
// RULE14: accumulator xor register, routed by destination, only zero flag.
// RULE15: accumulator xor literal into accumulator, only zero flag.
// RULE16: idle advances PC by one and changes nothing else.
// RULE17: zero flag follows whether the result is zero; addresses 0 to 127.
`timescale 1ns/1ps
module cies_core #(
	parameter int STACK_DEPTH = cies_pkg::STACK_DEPTH
) (
	input  wire logic                          CLK_I,
	input  wire logic                          RESETN_I,
	input  wire logic                          PSEL_I,
	input  wire logic                          PENABLE_I,
	input  wire logic                          PWRITE_I,
	input  wire logic [cies_pkg::APB_AW-1:0]   PADDR_I,
	input  wire logic [31:0]                   PWDATA_I,
	output logic      [31:0]                   PRDATA_O,
	output logic                               PREADY_O,
	output logic                               PSLVERR_O,
	output logic      [cies_pkg::PC_W-1:0]     PMEM_ADDR_O,
	output logic                               PMEM_RD_O,
	input  wire logic [cies_pkg::INSTR_W-1:0]  PMEM_DATA_I,
	output logic      [cies_pkg::FADDR_W-1:0]  FREG_ADDR_O,
	output logic                               FREG_RD_O,
	input  wire logic [7:0]                    FREG_RDATA_I,
	output logic                               FREG_WR_O,
	output logic      [7:0]                    FREG_WDATA_O,
	output logic                               OSC_RUN_O,
	output logic                               IRQ_EN_O
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	typedef enum logic [2:0] {
		ST_HALT   = 3'b000,
		ST_FETCH  = 3'b001,
		ST_FWAIT  = 3'b010,
		ST_DECODE = 3'b011,
		ST_OWAIT  = 3'b100,
		ST_EXEC   = 3'b101,
		ST_RET2   = 3'b110,
		ST_SLEEP  = 3'b111
	} cies_state_e;

	cies_state_e                       state_q;
	logic [cies_pkg::INSTR_W-1:0]      ir_q;
	logic [cies_pkg::PC_W-1:0]         pc_q;
	logic [cies_pkg::PC_W-1:0]         pc_inc;
	logic [7:0]                        acc_q;
	logic                              c_q;
	logic                              dc_q;
	logic                              z_q;
	logic                              pd_q;
	logic                              to_q;
	logic                              run_q;
	logic                              wdt_en_q;
	logic [cies_pkg::PC_W-1:0]         stack_mem [STACK_DEPTH];
	logic [SP_W-1:0]                   sp_q;
	logic [cies_pkg::PC_W-1:0]         stack_top;
	cies_pkg::cies_op_e                op;
	logic                              dest_f;
	logic                              exec;
	logic                              is_ret;
	logic [7:0]                        alu_res;
	logic                              alu_c;
	logic                              alu_dc;
	logic                              alu_z;
	logic                              upd_c;
	logic                              upd_dc;
	logic                              upd_z;
	logic [7:0]                        wdt_count;
	logic                              wdt_ovf;
	logic                              apb_setup;
	logic                              apb_wr;
	logic                              wake_req;
	logic                              push_req;
	logic                              mapped;
	logic [31:0]                       rd_mux;

	assign op        = cies_pkg::op_of(ir_q);
	assign dest_f    = ir_q[cies_pkg::DEST_BIT];
	assign exec      = (state_q == ST_EXEC);
	assign is_ret    = (op == cies_pkg::OP_IRQ_RET) || (op == cies_pkg::OP_RET_LIT) ||
		(op == cies_pkg::OP_RETURN);
	assign pc_inc    = pc_q + 13'h0001;
	assign stack_top = stack_mem[sp_q - {{(SP_W-1){1'b0}}, 1'b1}];

	cies_alu u_alu (
		.op_i     (op),
		.acc_i    (acc_q),
		.freg_i   (FREG_RDATA_I),
		.lit_i    (ir_q[7:0]),
		.carry_i  (c_q),
		.res_o    (alu_res),
		.c_o      (alu_c),
		.dc_o     (alu_dc),
		.z_o      (alu_z),
		.upd_c_o  (upd_c),
		.upd_dc_o (upd_dc),
		.upd_z_o  (upd_z)
	);

	// watchdog is cleared by executing sleep
	cies_wdt u_wdt (
		.clk_i   (CLK_I),
		.rst_n_i (RESETN_I),
		.en_i    (wdt_en_q),
		.clr_i   (exec && (op == cies_pkg::OP_SLEEP)), // [RULE8]
		.count_o (wdt_count),
		.ovf_o   (wdt_ovf)
	);

	// apb slave: zero wait state, answer registered in the setup cycle
	assign apb_setup = PSEL_I && !PENABLE_I;
	assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
	assign wake_req  = apb_wr && (PADDR_I == cies_pkg::OFS_CTRL) && PWDATA_I[cies_pkg::CTRL_WAKE_BIT];
	assign push_req  = apb_wr && (PADDR_I == cies_pkg::OFS_STACK);

	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (PADDR_I)
			cies_pkg::OFS_CTRL:   rd_mux = {28'h000_0000, wdt_en_q, IRQ_EN_O, 1'b0, run_q};
			cies_pkg::OFS_STATUS: rd_mux = {25'h000_0000, IRQ_EN_O, (state_q == ST_SLEEP), to_q, pd_q,
				z_q, dc_q, c_q};
			cies_pkg::OFS_ACC:    rd_mux = {24'h00_0000, acc_q};
			cies_pkg::OFS_PC:     rd_mux = {19'h0_0000, pc_q};
			cies_pkg::OFS_STACK:  rd_mux = {19'h0_0000, stack_top};
			cies_pkg::OFS_WDT:    rd_mux = {24'h00_0000, wdt_count};
			default:              mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end
		else
		begin
			PREADY_O  <= apb_setup;
			PSLVERR_O <= apb_setup && !mapped;
			PRDATA_O  <= (apb_setup && !PWRITE_I) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			run_q    <= 1'b0;
			wdt_en_q <= 1'b0;
		end
		else if (apb_wr && (PADDR_I == cies_pkg::OFS_CTRL))
		begin
			run_q    <= PWDATA_I[cies_pkg::CTRL_RUN_BIT];
			wdt_en_q <= PWDATA_I[cies_pkg::CTRL_WDT_EN_BIT];
		end
	end

	// hardware set on interrupt return wins over a software write
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			IRQ_EN_O <= 1'b0;
		else if (exec && (op == cies_pkg::OP_IRQ_RET))
			IRQ_EN_O <= 1'b1; // [RULE2]
		else if (apb_wr && (PADDR_I == cies_pkg::OFS_CTRL))
			IRQ_EN_O <= PWDATA_I[cies_pkg::CTRL_GIE_BIT];
	end

	// return stack: software pushes, returns pop
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			sp_q <= '0;
		else if (exec && is_ret)
			sp_q <= sp_q - {{(SP_W-1){1'b0}}, 1'b1}; // [RULE10]
		else if (push_req)
		begin
			stack_mem[sp_q] <= PWDATA_I[cies_pkg::PC_W-1:0];
			sp_q            <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
		end
	end

	// sequencer
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			state_q <= ST_HALT;
		else
		begin
			unique case (state_q)
				ST_HALT:   state_q <= run_q ? ST_FETCH : ST_HALT;
				ST_FETCH:  state_q <= run_q ? ST_FWAIT : ST_HALT;
				ST_FWAIT:  state_q <= ST_DECODE;
				ST_DECODE: state_q <= ST_OWAIT;
				ST_OWAIT:  state_q <= ST_EXEC;
				ST_EXEC:
				begin
					if (is_ret)
						state_q <= ST_RET2; // [RULE4] [RULE10]
					else if (op == cies_pkg::OP_SLEEP)
						state_q <= ST_SLEEP; // [RULE9]
					else
						state_q <= ST_FETCH;
				end
				ST_RET2:   state_q <= ST_FETCH;
				ST_SLEEP:  state_q <= (wake_req || wdt_ovf) ? ST_FETCH : ST_SLEEP;
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			OSC_RUN_O <= 1'b1;
		else if (exec && (op == cies_pkg::OP_SLEEP))
			OSC_RUN_O <= 1'b0; // [RULE9]
		else if (state_q == ST_SLEEP && (wake_req || wdt_ovf))
			OSC_RUN_O <= 1'b1;
	end

	// fetch port
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			PMEM_RD_O   <= 1'b0;
			PMEM_ADDR_O <= cies_pkg::PC_RST;
			ir_q        <= '0;
		end
		else
		begin
			PMEM_RD_O <= (state_q == ST_FETCH) && run_q;
			if (state_q == ST_FETCH)
				PMEM_ADDR_O <= pc_q;
			if (state_q == ST_DECODE)
				ir_q <= PMEM_DATA_I;
		end
	end

	// program counter
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			pc_q <= cies_pkg::PC_RST;
		else if (exec)
			pc_q <= is_ret ? stack_top : pc_inc; // [RULE2] [RULE4] [RULE10] [RULE16]
	end

	// file register port
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			FREG_ADDR_O  <= '0;
			FREG_RD_O    <= 1'b0;
			FREG_WR_O    <= 1'b0;
			FREG_WDATA_O <= 8'h00;
		end
		else
		begin
			if (state_q == ST_DECODE)
				FREG_ADDR_O <= PMEM_DATA_I[cies_pkg::FADDR_W-1:0]; // [RULE17]
			FREG_RD_O <= (state_q == ST_DECODE) && cies_pkg::reads_freg(cies_pkg::op_of(PMEM_DATA_I));
			FREG_WR_O <= exec && ((op == cies_pkg::OP_STORE_ACC) ||
				(cies_pkg::reads_freg(op) && dest_f)); // [RULE3] [RULE7]
			if (exec)
				FREG_WDATA_O <= (op == cies_pkg::OP_STORE_ACC) ? acc_q : alu_res; // [RULE3]
		end
	end

	// accumulator
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			acc_q <= cies_pkg::ACC_RST;
		else if (exec)
		begin
			unique case (op)
				cies_pkg::OP_LOAD_LIT, cies_pkg::OP_RET_LIT, cies_pkg::OP_LIT_SUB, cies_pkg::OP_XOR_LIT:
					acc_q <= alu_res; // [RULE1] [RULE4] [RULE11] [RULE15]
				cies_pkg::OP_ROT_LEFT, cies_pkg::OP_ROT_RIGHT, cies_pkg::OP_REG_SUB, cies_pkg::OP_NIB_SWAP,
				cies_pkg::OP_XOR_REG:
					if (!dest_f)
						acc_q <= alu_res; // [RULE5] [RULE6] [RULE7] [RULE12] [RULE13] [RULE14]
				default:
					acc_q <= acc_q;
			endcase
		end
	end

	// arithmetic flags
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			c_q  <= 1'b0;
			dc_q <= 1'b0;
			z_q  <= 1'b0;
		end
		else if (exec)
		begin
			if (upd_c)
				c_q <= alu_c; // [RULE5] [RULE6] [RULE11] [RULE12]
			if (upd_dc)
				dc_q <= alu_dc; // [RULE11] [RULE12]
			if (upd_z)
				z_q <= alu_z; // [RULE14] [RULE15] [RULE17]
		end
	end

	// power status: sleep sets expiry over a same-cycle watchdog overflow
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			pd_q <= cies_pkg::PD_RST;
			to_q <= cies_pkg::TO_RST;
		end
		else if (exec && (op == cies_pkg::OP_SLEEP))
		begin
			pd_q <= 1'b0; // [RULE8]
			to_q <= 1'b1; // [RULE8]
		end
		else if (wdt_ovf)
			to_q <= 1'b0;
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);

	sequence exec_of(cies_pkg::cies_op_e o);
		exec && (op == o);
	endsequence

	sequence two_cycle_ret;
		(state_q == ST_RET2) ##1 (state_q == ST_FETCH);
	endsequence

	load_literal_a: assert property (exec_of(cies_pkg::OP_LOAD_LIT) |=> // [RULE1]
		acc_q == $past(ir_q[7:0]) && $stable({c_q, dc_q, z_q}))
		else $error("load literal result or flags wrong");
	irq_return_a: assert property (exec_of(cies_pkg::OP_IRQ_RET) |=> // [RULE2]
		IRQ_EN_O && pc_q == $past(stack_top) && $stable({c_q, dc_q, z_q}))
		else $error("interrupt return wrong");
	store_acc_a: assert property (exec_of(cies_pkg::OP_STORE_ACC) |=> // [RULE3]
		FREG_WR_O && FREG_WDATA_O == $past(acc_q) && FREG_ADDR_O == $past(ir_q[6:0]))
		else $error("store accumulator write wrong");
	ret_literal_a: assert property (exec_of(cies_pkg::OP_RET_LIT) |=> // [RULE4]
		acc_q == $past(ir_q[7:0]) && pc_q == $past(stack_top) ##0 two_cycle_ret)
		else $error("literal return wrong");
	rotate_left_a: assert property (exec_of(cies_pkg::OP_ROT_LEFT) |=> // [RULE5]
		(dest_f ? FREG_WDATA_O : acc_q) == {$past(FREG_RDATA_I[6:0]), $past(c_q)} &&
		c_q == $past(FREG_RDATA_I[7]) && $stable({dc_q, z_q}))
		else $error("rotate left wrong");
	rotate_right_a: assert property (exec_of(cies_pkg::OP_ROT_RIGHT) |=> // [RULE6]
		(dest_f ? FREG_WDATA_O : acc_q) == {$past(c_q), $past(FREG_RDATA_I[7:1])} &&
		c_q == $past(FREG_RDATA_I[0]) && $stable({dc_q, z_q}))
		else $error("rotate right wrong");
	dest_select_a: assert property (exec && cies_pkg::reads_freg(op) |=> // [RULE7]
		FREG_WR_O == $past(dest_f) && (dest_f || acc_q == $past(alu_res)))
		else $error("destination routing wrong");
	sleep_status_a: assert property (exec_of(cies_pkg::OP_SLEEP) |=> // [RULE8]
		to_q && !pd_q && wdt_count == 8'h00)
		else $error("sleep status wrong");
	sleep_halt_a: assert property (exec_of(cies_pkg::OP_SLEEP) |=> // [RULE9]
		!OSC_RUN_O && state_q == ST_SLEEP && !PMEM_RD_O)
		else $error("sleep did not halt");
	return_a: assert property (exec_of(cies_pkg::OP_RETURN) |=> // [RULE10]
		pc_q == $past(stack_top) && $stable({c_q, dc_q, z_q, acc_q}) ##0 two_cycle_ret)
		else $error("subroutine return wrong");
	lit_sub_a: assert property (exec_of(cies_pkg::OP_LIT_SUB) |=> // [RULE11]
		acc_q == 8'($past(ir_q[7:0]) - $past(acc_q)) && c_q == ($past(ir_q[7:0]) >= $past(acc_q)) &&
		dc_q == ($past(ir_q[3:0]) >= $past(acc_q[3:0])))
		else $error("literal subtract wrong");
	reg_sub_a: assert property (exec_of(cies_pkg::OP_REG_SUB) ##0 dest_f |=> // [RULE12]
		FREG_WDATA_O == 8'($past(FREG_RDATA_I) - $past(acc_q)) && z_q == (FREG_WDATA_O == 8'h00))
		else $error("register subtract wrong");
	nibble_swap_a: assert property (exec_of(cies_pkg::OP_NIB_SWAP) |=> // [RULE13]
		(dest_f ? FREG_WDATA_O : acc_q) == {$past(FREG_RDATA_I[3:0]), $past(FREG_RDATA_I[7:4])} &&
		$stable({c_q, dc_q, z_q}))
		else $error("nibble swap wrong");
	xor_reg_a: assert property (exec_of(cies_pkg::OP_XOR_REG) ##0 !dest_f |=> // [RULE14]
		acc_q == ($past(acc_q) ^ $past(FREG_RDATA_I)) && $stable({c_q, dc_q}))
		else $error("register xor wrong");
	xor_lit_a: assert property (exec_of(cies_pkg::OP_XOR_LIT) |=> // [RULE15]
		acc_q == ($past(acc_q) ^ $past(ir_q[7:0])) && $stable(c_q))
		else $error("literal xor wrong");
	idle_step_a: assert property (exec_of(cies_pkg::OP_IDLE) |=> // [RULE16]
		pc_q == $past(pc_inc) && !FREG_WR_O && $stable({acc_q, c_q, dc_q, z_q}))
		else $error("idle changed state");
	zero_flag_a: assert property (exec && (op == cies_pkg::OP_XOR_LIT || op == cies_pkg::OP_LIT_SUB) |=> // [RULE17]
		z_q == (acc_q == 8'h00))
		else $error("zero flag wrong");

endmodule : cies_core

/* sim/cies_mem_model.sv */
/*
 * cies_mem_model: program memory and file registers beside the core.
 * Assumes read strobes are one-cycle pulses answered in the next cycle.
 */
`timescale 1ns/1ps
module cies_mem_model (
	input  wire logic        clk_i,
	input  wire logic [12:0] pmem_addr_i,
	input  wire logic        pmem_rd_i,
	output logic      [13:0] pmem_data_o,
	input  wire logic [6:0]  freg_addr_i,
	input  wire logic        freg_rd_i,
	output logic      [7:0]  freg_rdata_o,
	input  wire logic        freg_wr_i,
	input  wire logic [7:0]  freg_wdata_i
);
	logic [13:0] pmem [0:255];
	logic [7:0]  freg [0:127];

	// outside an answer the lines toggle so stale data never looks valid
	always @(posedge clk_i)
	begin
		pmem_data_o  <= pmem_rd_i ? pmem[pmem_addr_i[7:0]] : ~pmem_data_o;
		freg_rdata_o <= freg_rd_i ? freg[freg_addr_i] : ~freg_rdata_o;
		if (freg_wr_i)
			freg[freg_addr_i] <= freg_wdata_i;
	end
endmodule : cies_mem_model

/* sim/test_cies_core.sv */
/*
 * test_cies_core: runs short programs through the core and checks results.
 * Assumes the core answers APB with no wait state and halts in sleep.
 */
`timescale 1ns/1ps
module test_cies_core;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pmrd, frd, fwr, osc, irq_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [12:0] pmaddr;
	logic [13:0] pmdata;
	logic [6:0]  faddr;
	logic [7:0]  frdata, fwdata;
	int          errors, check_count;

	cies_core dut (.CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PMEM_ADDR_O(pmaddr), .PMEM_RD_O(pmrd), .PMEM_DATA_I(pmdata), .FREG_ADDR_O(faddr),
		.FREG_RD_O(frd), .FREG_RDATA_I(frdata), .FREG_WR_O(fwr), .FREG_WDATA_O(fwdata),
		.OSC_RUN_O(osc), .IRQ_EN_O(irq_en));

	cies_mem_model mem (.clk_i(clk), .pmem_addr_i(pmaddr), .pmem_rd_i(pmrd), .pmem_data_o(pmdata),
		.freg_addr_i(faddr), .freg_rd_i(frd), .freg_rdata_o(frdata), .freg_wr_i(fwr), .freg_wdata_i(fwdata));

	task close_out;
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic se);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        se;
		apb(1'b0, a, 32'h0000_0000, rd, se);
		chk(rd, exp);
	endtask : rd_chk

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        se;
		apb(1'b1, a, d, rd, se);
	endtask : wr

	task wait_osc(input logic lvl);
		int n;
		n = 0;
		while (osc !== lvl && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, osc}, {31'h0, lvl});
	endtask : wait_osc

	function automatic logic [13:0] ins(input logic [3:0] op, input logic [7:0] lo);
		return {op, 2'b00, lo};
	endfunction : ins

	task t_reset_vals;
		rd_chk(cies_pkg::OFS_STATUS, 32'h0000_0018);
		rd_chk(cies_pkg::OFS_ACC, 32'h0000_0000);
	endtask : t_reset_vals

	task t_unmapped;
		logic [31:0] rd;
		logic        se;
		apb(1'b0, 12'h0_0f0, 32'h0000_0000, rd, se);
		chk({31'h0, se}, 32'h0000_0001);
	endtask : t_unmapped

	task t_prog_a;
		wr(cies_pkg::OFS_CTRL, 32'h0000_0001);
		wait_osc(1'b0);
		rd_chk(cies_pkg::OFS_ACC, 32'h0000_0051);
		rd_chk(cies_pkg::OFS_STATUS, 32'h0000_0033);
		rd_chk(cies_pkg::OFS_PC, 32'h0000_000c);
		rd_chk(cies_pkg::OFS_WDT, 32'h0000_0000);
		chk({24'h0, mem.freg[7'h20]}, 32'h0000_0005);
		chk({24'h0, mem.freg[7'h10]}, 32'h0000_0002);
		chk({24'h0, mem.freg[7'h11]}, 32'h0000_00c3);
		chk({24'h0, mem.freg[7'h12]}, 32'h0000_0053);
	endtask : t_prog_a

	task t_returns;
		wr(cies_pkg::OFS_STACK, 32'h0000_0050);
		wr(cies_pkg::OFS_STACK, 32'h0000_0048);
		wr(cies_pkg::OFS_STACK, 32'h0000_0040);
		wr(cies_pkg::OFS_CTRL, 32'h0000_0003);
		wait_osc(1'b1);
		wait_osc(1'b0);
		rd_chk(cies_pkg::OFS_ACC, 32'h0000_007e);
		rd_chk(cies_pkg::OFS_PC, 32'h0000_0051);
		rd_chk(cies_pkg::OFS_CTRL, 32'h0000_0005);
		rd_chk(cies_pkg::OFS_STATUS, 32'h0000_0073);
		chk({31'h0, irq_en}, 32'h0000_0001);
	endtask : t_returns

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		#(3000 * 50);
		errors++;
		close_out();
	end

	initial
	begin
		errors = 0;
		check_count = 0;
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		mem.freg[7'h10] = 8'h81;
		mem.freg[7'h11] = 8'h3c;
		mem.freg[7'h12] = 8'h55;
		// acc flow: 05, rot 81, xor 00, 03, 02, then 02 xor 53 = 51
		mem.pmem[0]  = ins(4'h1, 8'h05);
		mem.pmem[1]  = ins(4'h3, 8'h20);
		mem.pmem[2]  = ins(4'h5, 8'h90);
		mem.pmem[3]  = ins(4'h6, 8'h10);
		mem.pmem[4]  = ins(4'hd, 8'h81);
		mem.pmem[5]  = ins(4'hb, 8'h91);
		mem.pmem[6]  = ins(4'h1, 8'h03);
		mem.pmem[7]  = ins(4'h9, 8'h05);
		mem.pmem[8]  = ins(4'ha, 8'h92);
		mem.pmem[9]  = ins(4'hc, 8'h12);
		mem.pmem[10] = ins(4'h0, 8'h00);
		mem.pmem[11] = ins(4'h7, 8'h00);
		mem.pmem[12] = ins(4'h4, 8'h7e);
		mem.pmem[64] = ins(4'h2, 8'h00);
		mem.pmem[72] = ins(4'h8, 8'h00);
		mem.pmem[80] = ins(4'h7, 8'h00);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_vals();
		t_unmapped();
		t_prog_a();
		t_returns();
		close_out();
	end
endmodule : test_cies_core
